//--- bridge_event_status.sv
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
// Behaviour
// - A master write start on an endpoint whose bus select is 0 sets status bit 29.
// - Any change of the synchronised bus power sense input, once the settle count is reached, sets status bit 28.
// - Completion of a bridge register read into the read value register sets bit 25.
// - Completion of a core register read whose value is stored for software sets bit 24.
// - Completion of a core register write also sets bit 24.
// - A bus error response during a master read transfer sets bit 23.
// - The master read transmit FIFO turning from full to not full sets bit 22.
// - The end of a master read transfer sets bit 21.
// - A bus error response during a master write transfer sets bit 20.
module bridge_event_status (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // master write side events
    input  wire logic        mw_start_i,
    input  wire logic        ep_bus_sel_i,
    input  wire logic        mw_active_i,
    input  wire logic        mw_ahb_error_i,
    // master read side events
    input  wire logic        mr_active_i,
    input  wire logic        mr_ahb_error_i,
    input  wire logic        mr_fifo_full_i,
    input  wire logic        mr_done_i,
    // register access completions
    input  wire logic        bridge_read_done_i,
    input  wire logic        core_read_done_i,
    input  wire logic        core_write_done_i,
    // asynchronous pin
    input  wire logic        bus_power_sense_input_i,
    // outputs
    output logic             master_read_block_reset_o,
    output logic             master_write_block_reset_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    localparam int FW = irq_status_pkg::FLAG_W;

    logic [FW-1:0]                  flags_w;
    irq_status_pkg::event_flags_t   flags_s;
    irq_status_pkg::event_flags_t   set_s;
    logic [FW-1:0]                  clr_w;
    logic [FW-1:0]                  enable_r;
    logic [1:0]                     control_r;
    logic                           irq_r;
    logic                           ack_r;
    logic [31:0]                    rdata_r;
    logic [31:0]                    rdata_nxt;
    logic                           wr_take;
    logic                           rd_take;
    logic [31:0]                    wmask;
    logic                           pwr_meta_r;
    logic                           pwr_sync_r;
    logic                           pwr_prev_r;
    logic [1:0]                     pwr_settle_r;
    logic                           pwr_change;
    logic                           fifo_full_prev_r;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // expand byte selects into a bit mask
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    // upper flag field of a masked write word
    function automatic logic [FW-1:0] upper_field(input logic [31:0] d, input logic [31:0] m);
        logic [31:0] v;
        v = d & m;
        return v[31:irq_status_pkg::FLAG_LSB];
    endfunction

    // positions of the eight live flags; reserved positions stay zero
    function automatic logic [FW-1:0] live_bits();
        logic [FW-1:0] m;
        m = '0;
        m[irq_status_pkg::BIT_MW_RERR - irq_status_pkg::FLAG_LSB]   = 1'b1;
        m[irq_status_pkg::BIT_POWER - irq_status_pkg::FLAG_LSB]     = 1'b1;
        m[irq_status_pkg::BIT_BRIDGE_RD - irq_status_pkg::FLAG_LSB] = 1'b1;
        m[irq_status_pkg::BIT_CORE_ACC - irq_status_pkg::FLAG_LSB]  = 1'b1;
        m[irq_status_pkg::BIT_MR_AHBERR - irq_status_pkg::FLAG_LSB] = 1'b1;
        m[irq_status_pkg::BIT_MR_SPACE - irq_status_pkg::FLAG_LSB]  = 1'b1;
        m[irq_status_pkg::BIT_MR_DONE - irq_status_pkg::FLAG_LSB]   = 1'b1;
        m[irq_status_pkg::BIT_MW_AHBERR - irq_status_pkg::FLAG_LSB] = 1'b1;
        return m;
    endfunction

    // ------------------------------------------------------------------------
    // wishbone handshake
    // ------------------------------------------------------------------------

    // a write takes effect at the edge where the master sees ack high
    assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    // read data is latched as ack rises, so it is stable while ack is high
    assign rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
    assign wmask   = byte_mask(wb_sel_i);

    // one cycle of ack per request, dropped in the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    // read mux; unmapped and write-only addresses read as zero
    always_comb begin
        rdata_nxt = irq_status_pkg::RDATA_RST;
        if (wb_adr_i == irq_status_pkg::OFF_STATUS) begin
            rdata_nxt[31:irq_status_pkg::FLAG_LSB] = flags_w;
        end else if (wb_adr_i == irq_status_pkg::OFF_ENABLE) begin
            rdata_nxt[31:irq_status_pkg::FLAG_LSB] = enable_r;
        end else if (wb_adr_i == irq_status_pkg::OFF_CONTROL) begin
            rdata_nxt[1:0] = control_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= irq_status_pkg::RDATA_RST;
        end else if (rd_take) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------------

    // enable register, reserved positions never store a one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_r <= irq_status_pkg::ENABLE_RST;
        end else if (wr_take && wb_adr_i == irq_status_pkg::OFF_ENABLE) begin
            enable_r <= ((enable_r & ~upper_field(32'hFFFF_FFFF, wmask))
                      | upper_field(wb_dat_i, wmask)) & live_bits();
        end
    end

    // block reset controls are levels: software writes one, then zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_r <= irq_status_pkg::CONTROL_RST;
        end else if (wr_take && wb_adr_i == irq_status_pkg::OFF_CONTROL && wb_sel_i[0]) begin
            control_r <= wb_dat_i[1:0];
        end
    end

    // write one to clear, through the status word or the clear register
    always_comb begin
        clr_w = '0;
        if (wr_take && (wb_adr_i == irq_status_pkg::OFF_STATUS
                     || wb_adr_i == irq_status_pkg::OFF_CLEAR)) begin
            clr_w = upper_field(wb_dat_i, wmask);
        end
    end

    // ------------------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------------------

    // bus power pin: two flops before anything looks at it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_meta_r <= 1'b0;
            pwr_sync_r <= 1'b0;
            pwr_prev_r <= 1'b0;
        end else begin
            pwr_meta_r <= bus_power_sense_input_i;
            pwr_sync_r <= pwr_meta_r;
            pwr_prev_r <= pwr_sync_r;
        end
    end

    // hold off edge detection until the synchroniser has filled,
    // otherwise a pin that is high at reset looks like a change
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_settle_r <= 2'h0;
        end else if (pwr_settle_r != irq_status_pkg::POWER_SETTLE) begin
            pwr_settle_r <= pwr_settle_r + 2'h1;
        end
    end

    assign pwr_change = (pwr_sync_r ^ pwr_prev_r)
                     && (pwr_settle_r == irq_status_pkg::POWER_SETTLE);

    // previous fifo full level, for the full to not-full edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_full_prev_r <= 1'b0;
        end else begin
            fifo_full_prev_r <= mr_fifo_full_i;
        end
    end

    // set strobes; reserved positions are never set
    always_comb begin
        set_s           = '0;
        set_s.mw_rerr   = mw_start_i && !ep_bus_sel_i;
        set_s.power     = pwr_change;
        set_s.bridge_rd = bridge_read_done_i;
        set_s.core_acc  = core_read_done_i || core_write_done_i;
        set_s.mr_ahberr = mr_active_i && mr_ahb_error_i;
        set_s.mr_space  = fifo_full_prev_r && !mr_fifo_full_i;
        set_s.mr_done   = mr_done_i;
        set_s.mw_ahberr = mw_active_i && mw_ahb_error_i;
    end

    // sticky flag storage, set wins over a simultaneous clear
    event_flag_bank #(
        .W      (FW)
    ) u_flags (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (set_s),
        .clr_i  (clr_w),
        .flags_o(flags_w)
    );

    assign flags_s = flags_w;

    // ------------------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------------------

    // registered level: one cycle behind the flags, traded for a clean output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(flags_w & enable_r);
        end
    end

    assign wb_ack_o                   = ack_r;
    assign wb_dat_o                   = rdata_r;
    assign irq_o                      = irq_r;
    assign master_read_block_reset_o  = control_r[irq_status_pkg::CTL_MASTER_READ_BLOCK_RESET];
    assign master_write_block_reset_o = control_r[irq_status_pkg::CTL_MASTER_WRITE_BLOCK_RESET];

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_mw_read_error: assert property (
        mw_start_i && !ep_bus_sel_i |=> flags_s.mw_rerr)
        else $error("endpoint read error flag not set");

    a_mw_busy_ok: assert property (
        !flags_s.mw_rerr && mw_start_i && ep_bus_sel_i && !set_s.mw_rerr
        |=> !flags_s.mw_rerr)
        else $error("read error flag set with bus select high");

    a_power_edge: assert property (
        $past(pwr_settle_r) == irq_status_pkg::POWER_SETTLE
        && pwr_settle_r == irq_status_pkg::POWER_SETTLE
        && $changed(pwr_sync_r) |-> ##1 flags_s.power)
        else $error("power change flag not set");

    a_bridge_read: assert property (
        bridge_read_done_i |=> flags_s.bridge_rd)
        else $error("bridge read done flag not set");

    a_core_access: assert property (
        core_read_done_i || core_write_done_i |=> flags_s.core_acc)
        else $error("core access flag not set");

    a_mr_bus_err: assert property (
        mr_active_i && mr_ahb_error_i |=> flags_s.mr_ahberr)
        else $error("master read bus error flag not set");

    a_fifo_space: assert property (
        mr_fifo_full_i ##1 !mr_fifo_full_i |=> flags_s.mr_space)
        else $error("fifo space flag not set");

    a_mr_done: assert property (
        mr_done_i |=> flags_s.mr_done)
        else $error("master read done flag not set");

    a_mw_bus_err: assert property (
        mw_active_i && mw_ahb_error_i |=> flags_s.mw_ahberr)
        else $error("master write bus error flag not set");

    a_flag_sticky: assert property (
        (flags_w != '0) && (clr_w == '0) |=> (($past(flags_w) & ~flags_w) == '0))
        else $error("flag dropped without a clear");

    a_clear_works: assert property (
        wr_take && wb_adr_i == irq_status_pkg::OFF_CLEAR && wb_sel_i == 4'hF
        && wb_dat_i[31:24] == 8'hFF && set_s == '0 |=> flags_w[FW-1:4] == '0)
        else $error("clear write left a flag set");

    a_reserved_zero: assert property (
        !flags_s.rsv31 && !flags_s.rsv30 && !flags_s.rsv27 && !flags_s.rsv26)
        else $error("reserved status bit set");

    a_irq_level: assert property (
        (flags_w & enable_r) != '0 ##1 (flags_w & enable_r) != '0 |-> irq_o)
        else $error("interrupt low with enabled flag set");

    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    a_ack_timely: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");

    a_master_read_block_reset_ctl: assert property (
        wr_take && wb_adr_i == irq_status_pkg::OFF_CONTROL && wb_sel_i[0]
        |=> master_read_block_reset_o == $past(wb_dat_i[0]) [*2])
        else $error("master read reset control not taken");

    c_irq_fires: cover property (
        set_s.mr_ahberr && enable_r[irq_status_pkg::BIT_MR_AHBERR - irq_status_pkg::FLAG_LSB]
        ##2 irq_o);

    c_set_beats_clear: cover property (
        set_s.mr_done && clr_w[irq_status_pkg::BIT_MR_DONE - irq_status_pkg::FLAG_LSB]);

    c_power_toggle: cover property (
        set_s.power ##[1:50] set_s.power);

    c_status_read: cover property (
        rd_take && wb_adr_i == irq_status_pkg::OFF_STATUS && flags_w != '0);

endmodule

//--- irq_status_pkg.sv
// ----------------------------------------------------------------------------
// shared constants and types for the bridge event status block
// ----------------------------------------------------------------------------
package irq_status_pkg;

    // --------------------------------------------------------------------
    // register map (byte addresses on the wishbone bus)
    // --------------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS  = 8'h00;  // bridge_event_status, read, write 1 to clear
    localparam logic [7:0] OFF_ENABLE  = 8'h04;  // interrupt enable, same layout
    localparam logic [7:0] OFF_CLEAR   = 8'h08;  // write-only clear, same layout
    localparam logic [7:0] OFF_CONTROL = 8'h0C;  // transfer block reset controls

    // --------------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------------
    localparam int FLAG_LSB      = 20;  // lowest bit held by this block
    localparam int FLAG_W        = 12;  // bits 31 down to 20
    localparam int BIT_MW_RERR   = 29;
    localparam int BIT_POWER     = 28;
    localparam int BIT_BRIDGE_RD = 25;
    localparam int BIT_CORE_ACC  = 24;
    localparam int BIT_MR_AHBERR = 23;
    localparam int BIT_MR_SPACE  = 22;
    localparam int BIT_MR_DONE   = 21;
    localparam int BIT_MW_AHBERR = 20;
    localparam int CTL_MASTER_READ_BLOCK_RESET  = 0;
    localparam int CTL_MASTER_WRITE_BLOCK_RESET  = 1;

    // --------------------------------------------------------------------
    // reset values and timing
    // --------------------------------------------------------------------
    localparam logic [FLAG_W-1:0] FLAGS_RST   = 12'h000;
    localparam logic [FLAG_W-1:0] ENABLE_RST  = 12'h000;
    localparam logic [1:0]        CONTROL_RST = 2'h0;
    localparam logic [31:0]       RDATA_RST   = 32'h0000_0000;
    localparam logic [1:0]        POWER_SETTLE = 2'h3;  // cycles before power edges count

    // upper event flags in register order, msb first
    typedef struct packed {
        logic rsv31;
        logic rsv30;
        logic mw_rerr;
        logic power;
        logic rsv27;
        logic rsv26;
        logic bridge_rd;
        logic core_acc;
        logic mr_ahberr;
        logic mr_space;
        logic mr_done;
        logic mw_ahberr;
    } event_flags_t;

endpackage

//--- event_flag_bank.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// bank of sticky flags; a set in the same cycle as a clear wins
// ----------------------------------------------------------------------------
module event_flag_bank #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // set and clear strobes, one bit per flag
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    // flag state
    output logic      [W-1:0] flags_o
);

    genvar k;

    // one flip-flop per flag, set has priority so no event is lost
    generate
        for (k = 0; k < W; k++) begin : g_flag
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    flags_o[k] <= 1'b0;
                end else if (set_i[k]) begin
                    flags_o[k] <= 1'b1;
                end else if (clr_i[k]) begin
                    flags_o[k] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

//--- usb_core_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// far side model: device core events and dma master state
// ----------------------------------------------------------------------------
module usb_core_model (
    // clock
    input  wire logic       clk_i,
    // block reset controls from the status block
    input  wire logic       mr_block_reset_i,
    input  wire logic       mw_block_reset_i,
    // events: mw start, mw err, mr err, mr done, bridge rd, core rd, core wr
    output logic      [6:0] pulse_o,
    // levels: bus select, mw active, mr active, fifo full, power pin
    output logic      [4:0] level_o
);
    // idle at time zero so no event is seen before the bench asks for one
    initial begin
        pulse_o = 7'h00;
        level_o = 5'h00;
    end

    // one pulse per call, so each flag sees a single sampled edge
    task automatic fire(input int k);
        @(posedge clk_i);
        pulse_o <= 7'h01 << k;
        @(posedge clk_i);
        pulse_o <= 7'h00;
    endtask

    // levels change right after an edge, like the real master logic
    task automatic set_level(input int k, input logic v);
        @(posedge clk_i);
        level_o[k] <= v;
    endtask

    // a transfer block held in reset abandons its transfer
    always @(posedge clk_i) begin
        if (mr_block_reset_i) begin
            level_o[2] <= 1'b0;
        end
        if (mw_block_reset_i) begin
            level_o[1] <= 1'b0;
        end
    end
endmodule

//--- bridge_event_status_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// self-checking bench for the bridge event status block
// ----------------------------------------------------------------------------
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module bridge_event_status_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [6:0]  pulse;
    logic [4:0]  level;
    logic        mr_rst;
    logic        mw_rst;
    logic        irq;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cycles = 0;

    // ------------------------------------------------------------------------
    // clock, design and far side
    // ------------------------------------------------------------------------
    always #5 clk = ~clk;

    bridge_event_status dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .mw_start_i(pulse[0]), .ep_bus_sel_i(level[0]),
        .mw_active_i(level[1]), .mw_ahb_error_i(pulse[1]), .mr_active_i(level[2]),
        .mr_ahb_error_i(pulse[2]), .mr_fifo_full_i(level[3]), .mr_done_i(pulse[3]),
        .bridge_read_done_i(pulse[4]), .core_read_done_i(pulse[5]),
        .core_write_done_i(pulse[6]), .bus_power_sense_input_i(level[4]),
        .master_read_block_reset_o(mr_rst), .master_write_block_reset_o(mw_rst),
        .irq_o(irq)
    );

    usb_core_model pm (
        .clk_i(clk), .mr_block_reset_i(mr_rst), .mw_block_reset_i(mw_rst),
        .pulse_o(pulse), .level_o(level)
    );

    // ------------------------------------------------------------------------
    // bus tasks and closing
    // ------------------------------------------------------------------------
    // classic cycle; the wait has no bound of its own, so only the bench ceiling stops a silent slave from hanging us
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        n = 0;
        // only ack or the bench ceiling ends this wait
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        `CHK("ack", 1'b1, wb_ack_o)
        `CHK("ack latency", 2, n)
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 4'h0, 32'h0000_0000);
        `CHK(nm, e, rdat)
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // generous ceiling; the full run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            fail_count++;
            end_sim();
        end
    end

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_events();
        int bits [7] = '{29, 20, 23, 21, 25, 24, 24};
        pm.set_level(1, 1'b1);
        pm.set_level(2, 1'b1);
        for (int k = 0; k < 7; k++) begin
            pm.fire(k);
            rd_chk("event flag", 8'h00, 32'h1 << bits[k]);
            bus(1'b1, 8'h00, 4'hF, 32'h1 << bits[k]);
            rd_chk("flag cleared", 8'h00, 32'h0000_0000);
            // after a bus error software pulses that block's reset before reuse
            if (k == 1 || k == 2) begin
                bus(1'b1, 8'h0C, 4'h1, 32'(3 - k));
                bus(1'b1, 8'h0C, 4'h1, 32'h0000_0000);
            end
        end
        // errors and starts outside their qualifying state must not count
        pm.set_level(0, 1'b1);
        pm.set_level(1, 1'b0);
        pm.set_level(2, 1'b0);
        for (int k = 0; k < 3; k++) pm.fire(k);
        rd_chk("unqualified", 8'h00, 32'h0000_0000);
        pm.set_level(0, 1'b0);
    endtask

    task automatic t_sticky();
        pm.fire(3);
        pm.fire(6);
        bus(1'b1, 8'h00, 4'hF, 32'h0000_0000);
        rd_chk("zero write", 8'h00, 32'h0120_0000);
        bus(1'b1, 8'h08, 4'h3, 32'h0020_0000);
        rd_chk("masked clear", 8'h00, 32'h0120_0000);
        bus(1'b1, 8'h08, 4'hF, 32'h0020_0000);
        rd_chk("clear reg", 8'h00, 32'h0100_0000);
        rd_chk("clear reads", 8'h08, 32'h0000_0000);
        // the done pulse lands on the ack edge of its own clear: set must win
        fork
            bus(1'b1, 8'h08, 4'hF, 32'h0020_0000);
            begin
                @(posedge clk);
                pm.fire(3);
            end
        join
        rd_chk("set beats clear", 8'h00, 32'h0120_0000);
        bus(1'b1, 8'h00, 4'hF, 32'hFFFF_FFFF);
        rd_chk("reserved", 8'h00, 32'h0000_0000);
        bus(1'b1, 8'h10, 4'hF, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
    endtask

    task automatic t_irq();
        bus(1'b1, 8'h04, 4'hF, 32'hFFFF_FFFF);
        rd_chk("enable live", 8'h04, 32'h33F0_0000);
        bus(1'b1, 8'h04, 4'hF, 32'h0020_0000);
        rd_chk("enable", 8'h04, 32'h0020_0000);
        pm.fire(3);
        repeat (2) @(posedge clk);
        #1 `CHK("irq set", 1'b1, irq)
        bus(1'b1, 8'h04, 4'hF, 32'h0000_0000);
        repeat (2) @(posedge clk);
        #1 `CHK("irq masked", 1'b0, irq)
        rd_chk("flag kept", 8'h00, 32'h0020_0000);
        bus(1'b1, 8'h04, 4'hF, 32'h0020_0000);
        repeat (2) @(posedge clk);
        #1 `CHK("irq again", 1'b1, irq)
        bus(1'b1, 8'h00, 4'hF, 32'h0020_0000);
        repeat (2) @(posedge clk);
        #1 `CHK("irq cleared", 1'b0, irq)
    endtask

    task automatic t_fifo_power();
        pm.set_level(3, 1'b1);
        repeat (3) @(posedge clk);
        rd_chk("fifo full", 8'h00, 32'h0000_0000);
        pm.set_level(3, 1'b0);
        rd_chk("fifo space", 8'h00, 32'h0040_0000);
        pm.set_level(3, 1'b1);
        rd_chk("space sticky", 8'h00, 32'h0040_0000);
        bus(1'b1, 8'h00, 4'hF, 32'h0040_0000);
        pm.set_level(4, 1'b1);
        repeat (6) @(posedge clk);
        rd_chk("power rise", 8'h00, 32'h1000_0000);
        bus(1'b1, 8'h00, 4'hF, 32'h1000_0000);
        pm.set_level(4, 1'b0);
        repeat (6) @(posedge clk);
        rd_chk("power fall", 8'h00, 32'h1000_0000);
        // full-word clear through the write-only clear register
        bus(1'b1, 8'h08, 4'hF, 32'hFFFF_FFFF);
        rd_chk("clear all", 8'h00, 32'h0000_0000);
    endtask

    task automatic t_block_reset();
        pm.set_level(2, 1'b1);
        pm.set_level(1, 1'b1);
        bus(1'b1, 8'h0C, 4'h1, 32'h0000_0001);
        #1 `CHK("master_read_block_reset", 1'b1, mr_rst)
        pm.fire(2);
        rd_chk("mr halted", 8'h00, 32'h0000_0000);
        bus(1'b1, 8'h0C, 4'h1, 32'h0000_0002);
        rd_chk("control", 8'h0C, 32'h0000_0002);
        #1 `CHK("master_write_block_reset", 1'b1, mw_rst)
        pm.fire(1);
        rd_chk("mw halted", 8'h00, 32'h0000_0000);
        bus(1'b1, 8'h0C, 4'h1, 32'h0000_0000);
        #1 `CHK("resets off", 2'h0, {mw_rst, mr_rst})
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk("status rst", 8'h00, 32'h0000_0000);
        rd_chk("enable rst", 8'h04, 32'h0000_0000);
        rd_chk("control rst", 8'h0C, 32'h0000_0000);
        `CHK("irq rst", 1'b0, irq)
        t_events();
        t_sticky();
        t_irq();
        t_fifo_power();
        t_block_reset();
        end_sim();
    end
endmodule
